// *** verilog/flic_defines.svh ***
// constants of the four level interrupt controller
// What this block does
// - thirteen sources arranged in four priority levels.
// - each source has its own enable bit; disabled sources never serviced.
// - global enable bit cleared blocks every source request at once; cpu_wake is not gated by it.
// - level of each source is high bit plus low bit from register pairs.
// - running routine preempted only by strictly higher priority request.
// - routine at highest level is never interrupted.
// - simultaneous requests of different levels: higher level serviced first.
// - equal level ties broken by fixed rank, external 0 first, serial bus timer last.
// - each source vectors to its fixed address in eight byte steps.
// - only external, brownout, keypad, comparators, watchdog, converter wake CPU.
// - trigger bit 0 means request while pin sampled low.
// - trigger bit 1 sets flag on high sample followed by low sample.
// - pins sampled once per machine cycle; source holds levels six clocks.
// - edge request flag cleared by hardware when routine entered.
// - level request still low at routine end raises another interrupt.
// - level mode flag follows sampled pin, no software clear.
// - enabled external interrupt wakes processor from power down or idle.
`ifndef FLIC_DEFINES_SVH
`define FLIC_DEFINES_SVH
`define FLIC_NSRC 13
`define FLIC_MC_CLKS 6
`define FLIC_REG_IEN_A 4'h0
`define FLIC_REG_IEN_B 4'h1
`define FLIC_REG_PL_A 4'h2
`define FLIC_REG_PH_A 4'h3
`define FLIC_REG_PL_B 4'h4
`define FLIC_REG_PH_B 4'h5
`define FLIC_REG_TCTL 4'h6
`define FLIC_REG_STAT 4'h7
`define FLIC_REG_VEC 4'h8
`define FLIC_GIE_BIT 7
`define FLIC_IT0_BIT 0
`define FLIC_IT1_BIT 2
`define FLIC_IE0_BIT 1
`define FLIC_IE1_BIT 3
// wake capable sources, bit order = vector order
`define FLIC_WAKE_MASK 13'h0fa5
`endif

// *** verilog/flic_pkg.sv ***
// types of the four level interrupt controller
package flic_pkg;
    typedef logic [1:0] flic_level_t;
    typedef logic [3:0] flic_idx_t;
    typedef enum logic [1:0] {
        FLIC_IDLE = 2'b00,
        FLIC_RD = 2'b01,
        FLIC_WR = 2'b10
    } flic_bus_e;
endpackage

// *** verilog/flic_ext_sampler.sv ***
// external request pin sampler, once per machine cycle
`include "flic_defines.svh"
module flic_ext_sampler
    import flic_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic mc_tick,
    input wire logic pin_n,
    input wire logic edge_select,
    input wire logic ack,
    input wire logic sw_clear,
    output logic flag
);
    logic prev;
    logic edge_flag;
    logic next_prev;
    logic next_edge_flag;

    always_comb begin
        next_prev = prev;
        next_edge_flag = edge_flag;
        if (ack || sw_clear || !edge_select) begin
            next_edge_flag = 1'b0;
        end
        if (mc_tick) begin
            next_prev = pin_n;
            if (edge_select && prev && !pin_n) begin
                next_edge_flag = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prev <= 1'b1;
            edge_flag <= 1'b0;
        end else begin
            prev <= next_prev;
            edge_flag <= next_edge_flag;
        end
    end

    // level mode tracks last sample
    assign flag = edge_select ? edge_flag : !prev;
endmodule

// *** verilog/flic_core.sv ***
// four level interrupt controller with avalon register slave
`include "flic_defines.svh"
module flic_core
    import flic_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ext0_request_pin_n,
    input wire logic ext1_request_pin_n,
    input wire logic timer0_overflow_flag,
    input wire logic timer1_overflow_flag,
    input wire logic serial_tx_rx_flags,
    input wire logic brownout_flag,
    input wire logic serial_bus_attention_flag,
    input wire logic keypad_flag,
    input wire logic comparator_two_flag,
    input wire logic watchdog_overflow_flag,
    input wire logic converter_done_flag,
    input wire logic comparator_one_flag,
    input wire logic serial_bus_timer_flag,
    input wire logic cpu_ack,
    input wire logic cpu_reti,
    output logic cpu_irq,
    output logic [15:0] cpu_vector,
    output logic cpu_wake
);
    logic [7:0] irq_enable_reg_a;
    logic [7:0] irq_enable_reg_b;
    logic [7:0] prio_low_reg_a;
    logic [7:0] prio_high_reg_a;
    logic [7:0] prio_low_reg_b;
    logic [7:0] prio_high_reg_b;
    logic [7:0] timer_ctrl_reg;
    logic [3:0] active;
    logic [2:0] mc_cnt;
    logic mc_tick;
    logic ext0_request_flag;
    logic ext1_request_flag;
    logic [12:0] req;
    logic [12:0] en;
    flic_level_t lvl [13];
    logic [3:0] win_idx;
    logic win_found;
    flic_level_t win_lvl;
    logic [3:0] next_active;
    logic [2:0] next_mc_cnt;
    logic [7:0] next_ien_a;
    logic [7:0] next_ien_b;
    logic [7:0] next_pl_a;
    logic [7:0] next_ph_a;
    logic [7:0] next_pl_b;
    logic [7:0] next_ph_b;
    logic [7:0] next_tctl;
    logic [31:0] next_rdata;
    logic bus_busy;
    logic next_bus_busy;
    logic ack0;
    logic ack1;
    logic clr0;
    logic clr1;
    logic global_irq_enable;
    logic [15:0] next_vector;

    // rank of vector index 0..12: lower wins a tie
    localparam logic [3:0] RANK [13] = '{
        4'h1, // external 0
        4'h4, // timer 0
        4'h7, // external 1
        4'ha, // timer 1
        4'hc, // serial port
        4'h2, // brownout
        4'h5, // serial bus
        4'h8, // keypad
        4'hb, // comparator 2
        4'h3, // watchdog
        4'h6, // converter
        4'h9, // comparator 1
        4'hd // serial bus timer
    };
    // enable/priority bit position per source, bit 3 selects register b
    localparam logic [3:0] POS [13] = '{
        4'h0,
        4'h1,
        4'h2,
        4'h3,
        4'h4,
        4'h5,
        4'h8,
        4'h9,
        4'ha,
        4'h6,
        4'hc,
        4'hd,
        4'hf
    };
    // vector offset inside the table, vector = 8*n+3
    localparam logic [3:0] VSLOT [13] = '{
        4'h0,
        4'h1,
        4'h2,
        4'h3,
        4'h4,
        4'h5,
        4'h6,
        4'h7,
        4'h8,
        4'ha,
        4'hb,
        4'hc,
        4'he
    };

    function automatic logic pick(input logic [7:0] a, input logic [7:0] b,
                                  input logic [3:0] p);
        pick = p[3] ? b[p[2:0]] : a[p[2:0]];
    endfunction

    assign global_irq_enable = irq_enable_reg_a[`FLIC_GIE_BIT];

    // machine cycle tick
    always_comb begin
        next_mc_cnt = (mc_cnt == 3'(`FLIC_MC_CLKS - 1)) ? 3'h0 : mc_cnt + 3'h1;
    end
    assign mc_tick = (mc_cnt == 3'h0);

    assign ack0 = cpu_ack && cpu_irq && win_idx == 4'h0;
    assign ack1 = cpu_ack && cpu_irq && win_idx == 4'h2;
    assign clr0 = avs_write && !avs_waitrequest && avs_address == `FLIC_REG_TCTL &&
                  !avs_writedata[`FLIC_IE0_BIT];
    assign clr1 = avs_write && !avs_waitrequest && avs_address == `FLIC_REG_TCTL &&
                  !avs_writedata[`FLIC_IE1_BIT];

    flic_ext_sampler u_ext0 (
        .ref_clk(ref_clk),
        .rst(rst),
        .mc_tick(mc_tick),
        .pin_n(ext0_request_pin_n),
        .edge_select(timer_ctrl_reg[`FLIC_IT0_BIT]),
        .ack(ack0),
        .sw_clear(clr0),
        .flag(ext0_request_flag)
    );

    flic_ext_sampler u_ext1 (
        .ref_clk(ref_clk),
        .rst(rst),
        .mc_tick(mc_tick),
        .pin_n(ext1_request_pin_n),
        .edge_select(timer_ctrl_reg[`FLIC_IT1_BIT]),
        .ack(ack1),
        .sw_clear(clr1),
        .flag(ext1_request_flag)
    );

    assign req = {serial_bus_timer_flag, comparator_one_flag, converter_done_flag,
                  watchdog_overflow_flag, comparator_two_flag, keypad_flag,
                  serial_bus_attention_flag, brownout_flag, serial_tx_rx_flags,
                  timer1_overflow_flag, ext1_request_flag, timer0_overflow_flag,
                  ext0_request_flag};

    genvar g;
    generate
        for (g = 0; g < `FLIC_NSRC; g++) begin : g_src
            assign en[g] = pick(irq_enable_reg_a, irq_enable_reg_b, POS[g]);
            assign lvl[g] = {pick(prio_high_reg_a, prio_high_reg_b, POS[g]),
                             pick(prio_low_reg_a, prio_low_reg_b, POS[g])};
        end
    endgenerate

    // arbitration among enabled pending sources
    always_comb begin
        win_found = 1'b0;
        win_idx = 4'h0;
        win_lvl = 2'h0;
        for (int i = 0; i < `FLIC_NSRC; i++) begin
            if (req[i] && en[i] && global_irq_enable) begin
                if (!win_found || lvl[i] > win_lvl ||
                    (lvl[i] == win_lvl && RANK[i] < RANK[win_idx])) begin
                    win_found = 1'b1;
                    win_idx = 4'(i);
                    win_lvl = lvl[i];
                end
            end
        end
    end

    // preempt only above every level in service
    always_comb begin
        cpu_irq = 1'b0;
        if (win_found) begin
            cpu_irq = 1'b1;
            for (int l = 0; l < 4; l++) begin
                if (active[l] && 2'(l) >= win_lvl) begin
                    cpu_irq = 1'b0;
                end
            end
        end
    end

    // active level stack
    always_comb begin
        next_active = active;
        if (cpu_reti) begin
            for (int l = 0; l < 4; l++) begin
                if (active[l] && !(|(active >> (l + 1)))) begin
                    next_active[l] = 1'b0;
                end
            end
        end else if (cpu_ack && cpu_irq) begin
            next_active[win_lvl] = 1'b1;
        end
    end

    assign cpu_wake = |(req & en & 13'(`FLIC_WAKE_MASK));

    // register writes land on the accept edge
    always_comb begin
        next_ien_a = irq_enable_reg_a;
        next_ien_b = irq_enable_reg_b;
        next_pl_a = prio_low_reg_a;
        next_ph_a = prio_high_reg_a;
        next_pl_b = prio_low_reg_b;
        next_ph_b = prio_high_reg_b;
        next_tctl = timer_ctrl_reg;
        if (avs_write && !avs_waitrequest) begin
            case (avs_address)
                `FLIC_REG_IEN_A: next_ien_a = avs_writedata[7:0];
                `FLIC_REG_IEN_B: next_ien_b = avs_writedata[7:0];
                `FLIC_REG_PL_A: next_pl_a = avs_writedata[7:0];
                `FLIC_REG_PH_A: next_ph_a = avs_writedata[7:0];
                `FLIC_REG_PL_B: next_pl_b = avs_writedata[7:0];
                `FLIC_REG_PH_B: next_ph_b = avs_writedata[7:0];
                `FLIC_REG_TCTL: next_tctl = avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    // register slave, one wait cycle per access
    // read data loaded in the wait cycle so it stands at the accept edge
    always_comb begin
        next_bus_busy = (avs_read || avs_write) && !bus_busy;
        next_rdata = avs_readdata;
        if (avs_read && !bus_busy) begin
            case (avs_address)
                `FLIC_REG_IEN_A: next_rdata = {24'h0, irq_enable_reg_a};
                `FLIC_REG_IEN_B: next_rdata = {24'h0, irq_enable_reg_b};
                `FLIC_REG_PL_A: next_rdata = {24'h0, prio_low_reg_a};
                `FLIC_REG_PH_A: next_rdata = {24'h0, prio_high_reg_a};
                `FLIC_REG_PL_B: next_rdata = {24'h0, prio_low_reg_b};
                `FLIC_REG_PH_B: next_rdata = {24'h0, prio_high_reg_b};
                `FLIC_REG_TCTL: next_rdata = {24'h0, timer_ctrl_reg[7:4],
                                              ext1_request_flag, timer_ctrl_reg[2],
                                              ext0_request_flag, timer_ctrl_reg[0]};
                `FLIC_REG_STAT: next_rdata = {12'h0, active, 3'h0, req};
                `FLIC_REG_VEC: next_rdata = {11'h0, win_found, cpu_irq, 3'h0,
                                             cpu_vector};
                default: next_rdata = 32'h0;
            endcase
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !bus_busy;

    always_comb begin
        next_vector = {9'h0, VSLOT[win_idx], 3'h3};
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_enable_reg_a <= 8'h00;
            irq_enable_reg_b <= 8'h00;
            prio_low_reg_a <= 8'h00;
            prio_high_reg_a <= 8'h00;
            prio_low_reg_b <= 8'h00;
            prio_high_reg_b <= 8'h00;
            timer_ctrl_reg <= 8'h00;
        end else begin
            irq_enable_reg_a <= next_ien_a;
            irq_enable_reg_b <= next_ien_b;
            prio_low_reg_a <= next_pl_a;
            prio_high_reg_a <= next_ph_a;
            prio_low_reg_b <= next_pl_b;
            prio_high_reg_b <= next_ph_b;
            timer_ctrl_reg <= next_tctl;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0;
            bus_busy <= 1'b0;
        end else begin
            avs_readdata <= next_rdata;
            bus_busy <= next_bus_busy;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            active <= 4'h0;
        end else begin
            active <= next_active;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mc_cnt <= 3'h0;
        end else begin
            mc_cnt <= next_mc_cnt;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cpu_vector <= 16'h0003;
        end else begin
            cpu_vector <= next_vector;
        end
    end
endmodule

// *** dv/flic_core_asserts.sv ***
// checker of bus timing and cpu request relations
module flic_core_asserts (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic cpu_ack,
    input wire logic cpu_irq,
    input wire logic [15:0] cpu_vector
);
    timeunit 1ns;
    timeprecision 1ns;
    logic gie;
    wire logic rq = avs_read || avs_write;
    // shadow of the global enable bit
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            gie <= 1'b0;
        end else if (avs_write && !avs_waitrequest && avs_address == 4'h0) begin
            gie <= avs_writedata[7];
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_wait_first: assert property (rq && !$past(rq) |-> avs_waitrequest) else $error("no wait");
    a_wait_one: assert property (rq && avs_waitrequest |=> !avs_waitrequest) else $error("long wait");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 4'h8
        |-> avs_readdata == 32'h0) else $error("unmapped read");
    a_read_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("readdata moved");
    a_upper_zero: assert property (avs_readdata[31:21] == 11'h0) else $error("upper bits");
    a_global_off: assert property (!gie |-> !cpu_irq) else $error("irq while off");
    a_vector_form: assert property (cpu_irq |-> cpu_vector[2:0] == 3'h3
        && cpu_vector[15:7] == 9'h0) else $error("bad vector");
    a_ack_drops: assert property (cpu_ack && cpu_irq |=> !cpu_irq) else $error("irq kept");
    a_reset_out: assert property ($fell(rst) |-> !cpu_irq && cpu_vector == 16'h0003)
        else $error("reset outputs");
    cover property (cpu_ack && cpu_irq);
    cover property (cpu_irq && cpu_vector == 16'h0003);
    cover property (avs_read && avs_address > 4'h8 && !avs_waitrequest);
endmodule
bind flic_core flic_core_asserts u_flic_core_asserts (.*);

// *** dv/flic_cpu_model.sv ***
// cpu core model: enters and leaves service routines
module flic_cpu_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cpu_irq,
    input wire logic [15:0] cpu_vector,
    input wire logic take_en,
    input wire logic ret_req,
    output logic cpu_ack,
    output logic cpu_reti,
    output logic [15:0] got_vec
);
    timeunit 1ns;
    timeprecision 1ns;
    logic irq_q;
    wire logic go = take_en && cpu_irq && irq_q && !cpu_ack;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {irq_q, cpu_ack, cpu_reti, got_vec} <= '0;
        end else begin
            irq_q <= cpu_irq;
            // vector trails arbitration by one cycle
            cpu_ack <= go;
            if (go) begin
                got_vec <= cpu_vector;
            end
            cpu_reti <= ret_req && !cpu_reti;
        end
    end
endmodule

// *** dv/tb_flic_core.sv ***
// self-checking bench of the four level interrupt controller
module tb_flic_core;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rdat;
    logic avs_waitrequest, cpu_ack, cpu_reti, cpu_irq, cpu_wake;
    logic take_en = 1'b0, ret_req = 1'b0;
    logic [15:0] cpu_vector, got_vec;
    logic [12:0] src = 13'h0;
    int miscompares = 0, n_checks = 0, cyc = 0;
    localparam logic [3:0] ebit [13] = '{0, 1, 2, 3, 4, 5, 8, 9, 10, 6, 12, 13, 15};
    localparam logic [12:0] wake = 13'h0fa5;
    wire ext0_request_pin_n = !src[0], ext1_request_pin_n = !src[2];
    wire timer0_overflow_flag = src[1], timer1_overflow_flag = src[3];
    wire serial_tx_rx_flags = src[4], brownout_flag = src[5];
    wire serial_bus_attention_flag = src[6], keypad_flag = src[7];
    wire comparator_two_flag = src[8], watchdog_overflow_flag = src[9];
    wire converter_done_flag = src[10], comparator_one_flag = src[11];
    wire serial_bus_timer_flag = src[12];
    flic_core u_flic_core (.*);
    flic_cpu_model u_flic_cpu_model (.*);
    always #50 ref_clk = !ref_clk;
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        rdat = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic en(input logic [15:0] m);
        bus(1'b1, 4'h0, m[7:0]);
        bus(1'b1, 4'h1, m[15:8]);
    endtask
    task automatic take();
        take_en <= 1'b1;
        while (cpu_ack !== 1'b1) begin
            @(posedge ref_clk);
        end
        take_en <= 1'b0;
        wt(3);
    endtask
    task automatic ret();
        ret_req <= 1'b1;
        @(posedge ref_clk);
        ret_req <= 1'b0;
        wt(3);
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        wt(4);
        rst <= 1'b0;
        wt(1);
        for (int a = 0; a < 10; a++) begin
            bus(1'b0, a[3:0] | {4{a == 9}}, 8'h0);
            check("reset reg", rdat, (a == 8) ? 32'h3 : 32'h0);
        end
        en(16'h0002);
        src <= 13'h002;
        wt(14);
        check("global off", cpu_irq, 0);
        en(16'h0080);
        check("source off", cpu_irq, 0);
        $display("done gating");
        for (int s = 0; s < 13; s++) begin
            en(16'h0080 | (16'h1 << ebit[s]));
            src <= 13'h1 << s;
            wt(14);
            check("irq", cpu_irq, 1);
            check("vector", cpu_vector, 8 * (s < 9 ? s : s == 12 ? 14 : s + 1) + 3);
            check("wake", cpu_wake, wake[s]);
        end
        en(16'hffff);
        src <= 13'h222;
        wt(3);
        check("rank", cpu_vector, 32'h2b);
        src <= 13'h202;
        wt(3);
        check("rank", cpu_vector, 32'h53);
        $display("done vectors");
        bus(1'b1, 4'h2, 8'h58);
        bus(1'b1, 4'h3, 8'h52);
        bus(1'b0, 4'h3, 8'h0);
        check("prio read", rdat, 32'h52);
        src <= 13'h02a;
        wt(3);
        check("level", cpu_vector, 32'h0b);
        take();
        check("entry", got_vec, 32'h0b);
        src <= 13'h028;
        wt(3);
        check("lower waits", cpu_irq, 0);
        src <= 13'h038;
        wt(3);
        check("preempt", cpu_vector, 32'h23);
        take();
        src <= 13'h228;
        wt(3);
        check("top level", cpu_irq, 0);
        ret();
        check("release", cpu_vector, 32'h53);
        take();
        src <= 13'h028;
        ret();
        check("still held", cpu_irq, 0);
        ret();
        check("release", cpu_vector, 32'h1b);
        take();
        src <= 13'h0;
        ret();
        $display("done levels");
        en(16'h0081);
        src <= 13'h1;
        wt(14);
        check("ext level", cpu_vector, 32'h03);
        check("ext wake", cpu_wake, 1);
        bus(1'b0, 4'h6, 8'h0);
        check("level flag", rdat, 32'h2);
        take();
        ret();
        check("again", cpu_irq, 1);
        take();
        src <= 13'h0;
        wt(14);
        bus(1'b0, 4'h6, 8'h0);
        check("level flag", rdat, 32'h0);
        ret();
        bus(1'b1, 4'h6, 8'h01);
        src <= 13'h1;
        wt(14);
        src <= 13'h0;
        wt(14);
        bus(1'b0, 4'h6, 8'h0);
        check("edge flag", rdat, 32'h3);
        take();
        bus(1'b0, 4'h6, 8'h0);
        check("edge clear", rdat, 32'h1);
        ret();
        bus(1'b1, 4'h6, 8'h04);
        en(16'h0084);
        src <= 13'h004;
        wt(14);
        src <= 13'h0;
        wt(14);
        bus(1'b0, 4'h6, 8'h0);
        check("edge flag one", rdat, 32'hc);
        check("edge wake", cpu_wake, 1);
        take();
        check("edge entry", got_vec, 32'h13);
        bus(1'b0, 4'h6, 8'h0);
        check("edge clear one", rdat, 32'h4);
        ret();
        $display("done external");
        complete_run();
    end
endmodule
